// ### rtl/aurt_pkg.sv
/*
 Constants shared by the auto-reload up/down timer: register offsets,
 field positions, reset values and widths.
 Assumes a single clock domain and an 8-bit plain register port.
*/
// Operation
// - Up-count overflow: flag, interrupt, reload, keep running.
// - Trigger mode: pin falling edge forces a reload.
// - Direction mode: pin picks direction, no reload event.
// - Down-count match with reload value is underflow.
// - Underflow loads all ones and keeps running.
// - Select bit zero plus run bit starts counting.
// - Extension flag toggles per wrap, never interrupts.
package aurt_pkg;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int unsigned AURT_ADDR_W  = 4;
   localparam int unsigned AURT_DATA_W  = 8;
   localparam int unsigned AURT_COUNT_W = 16;
   localparam int unsigned AURT_STAT_W  = 2;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [3:0] AURT_REG_CTRL        = 4'h0;
   localparam logic [3:0] AURT_REG_COUNT_LOW   = 4'h1;
   localparam logic [3:0] AURT_REG_COUNT_HIGH  = 4'h2;
   localparam logic [3:0] AURT_REG_RELOAD_LOW  = 4'h3;
   localparam logic [3:0] AURT_REG_RELOAD_HIGH = 4'h4;
   localparam logic [3:0] AURT_REG_STATUS      = 4'h5;
   localparam logic [3:0] AURT_REG_IRQ_ENABLE  = 4'h6;
   localparam logic [3:0] AURT_REG_IRQ_CLEAR   = 4'h7;
   localparam logic [3:0] AURT_REG_EXT_FLAG    = 4'h8;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int unsigned AURT_CTRL_RUN  = 0;
   localparam int unsigned AURT_CTRL_CPRL = 1;
   localparam int unsigned AURT_CTRL_EXEN = 2;
   localparam int unsigned AURT_CTRL_DECREMENT_ENABLE = 3;
   localparam int unsigned AURT_STAT_OVF  = 0;
   localparam int unsigned AURT_STAT_TRIG = 1;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [3:0]  AURT_CTRL_RST   = 4'h0;
   localparam logic [15:0] AURT_COUNT_RST  = 16'h0000;
   localparam logic [15:0] AURT_RELOAD_RST = 16'h0000;
   localparam logic [15:0] AURT_ALL_ONES   = 16'hFFFF;
   localparam logic [1:0]  AURT_STAT_RST   = 2'h0;
   localparam logic [7:0]  AURT_RDATA_RST  = 8'h00;

endpackage : aurt_pkg

// ### rtl/aurt_fall_detect.sv
/*
 Falling-edge detector for the external timer pin.
 Assumes the pin is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module aurt_fall_detect
   import aurt_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic level,
   output logic      fall
);

   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = level;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   // A low level seen at reset release never counts as an edge.
   assign fall = prev & ~level;

endmodule : aurt_fall_detect

// ### rtl/aurt_count_step.sv
/*
 Combinational next-count step of the auto-reload timer.
 Assumes the caller registers the result and gates it by run state.
*/
`timescale 1ns/1ps
module aurt_count_step
   import aurt_pkg::*;
#(
   parameter int unsigned W = AURT_COUNT_W
)
(
   input  wire logic [W-1:0] count,
   input  wire logic [W-1:0] reload,
   input  wire logic         enable,
   input  wire logic         count_up,
   input  wire logic         trigger,
   output logic      [W-1:0] step_count,
   output logic              wrap
);

   always_comb begin
      step_count = count;
      wrap       = 1'b0;
      if (enable) begin
         if (trigger) begin
            step_count = reload;
         end else if (count_up) begin
            if (count == {W{1'b1}}) begin
               step_count = reload;
               wrap       = 1'b1;
            end else begin
               step_count = count + {{(W-1){1'b0}}, 1'b1};
            end
         end else begin
            if (count == reload) begin
               step_count = {W{1'b1}};
               wrap       = 1'b1;
            end else begin
               step_count = count - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule : aurt_count_step

// ### rtl/aurt_timer.sv
/*
 Top of the 16-bit auto-reload up/down timer with its register port
 and level interrupt.
 Assumes ext_timer_pin and all bus signals are synchronous to sys_clk,
 and that the bus master never raises both strobes at once.
*/
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module aurt_timer
   import aurt_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic [AURT_ADDR_W-1:0] addr,
   input  wire logic [AURT_DATA_W-1:0] wr_data,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [AURT_DATA_W-1:0] rd_data,
   input  wire logic                   ext_timer_pin,
   output logic                        irq,
   output logic                        extension_toggle_flag,
   output logic                        overflow_flag
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic                    run_control;
   logic                    capture_not_reload_select;
   logic                    ext_trigger_enable;
   logic                    decrement_enable;
   logic [AURT_COUNT_W-1:0] count;
   logic [AURT_COUNT_W-1:0] reload_value;
   logic [AURT_STAT_W-1:0]  status;
   logic [AURT_STAT_W-1:0]  irq_enable;

   logic                    next_run_control;
   logic                    next_capture_not_reload_select;
   logic                    next_ext_trigger_enable;
   logic                    next_decrement_enable;
   logic [AURT_COUNT_W-1:0] next_count;
   logic [AURT_COUNT_W-1:0] next_reload_value;
   logic [AURT_STAT_W-1:0]  next_status;
   logic [AURT_STAT_W-1:0]  next_irq_enable;
   logic                    next_extension_toggle_flag;
   logic                    next_irq;
   logic [AURT_DATA_W-1:0]  next_rd_data;

   // -----------------------------------------------------------------
   // Counting datapath
   // -----------------------------------------------------------------
   logic                    pin_fall;
   logic                    counting;
   logic                    count_up;
   logic                    trigger;
   logic [AURT_COUNT_W-1:0] step_count;
   logic                    wrap;
   logic [AURT_STAT_W-1:0]  events;
   logic [AURT_STAT_W-1:0]  clear_mask;

   aurt_fall_detect u_fall (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .level   (ext_timer_pin),
      .fall    (pin_fall)
   );

   // Counting only happens in auto-reload mode with the run bit set.
   assign counting = run_control & ~capture_not_reload_select;

   // In direction mode the pin picks the direction and never trigger-reloads.
   assign count_up = decrement_enable ?
                     ext_timer_pin : 1'b1;

   assign trigger = ext_trigger_enable & ~decrement_enable
                    & pin_fall;

   aurt_count_step #(
      .W (AURT_COUNT_W)
   ) u_step (
      .count      (count),
      .reload     (reload_value),
      .enable     (counting),
      .count_up   (count_up),
      .trigger    (trigger),
      .step_count (step_count),
      .wrap       (wrap)
   );

   // -----------------------------------------------------------------
   // Events and clears
   // -----------------------------------------------------------------
   always_comb begin
      events                 = '0;
      events[AURT_STAT_OVF]  = wrap;
      events[AURT_STAT_TRIG] = counting & trigger;
      clear_mask             = '0;
      if (wr_en && addr == AURT_REG_IRQ_CLEAR) begin
         clear_mask = wr_data[AURT_STAT_W-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      next_run_control               = run_control;
      next_capture_not_reload_select = capture_not_reload_select;
      next_ext_trigger_enable        = ext_trigger_enable;
      next_decrement_enable          = decrement_enable;
      next_count                     = step_count;
      next_reload_value              = reload_value;
      next_irq_enable                = irq_enable;
      // Wraps toggle the seventeenth bit; it is no interrupt source.
      next_extension_toggle_flag     = extension_toggle_flag ^ wrap;
      next_rd_data                   = AURT_RDATA_RST;

      if (wr_en) begin
         unique case (addr)
            AURT_REG_CTRL: begin
               next_run_control = wr_data[AURT_CTRL_RUN];
               next_capture_not_reload_select = wr_data[AURT_CTRL_CPRL];
               next_ext_trigger_enable        = wr_data[AURT_CTRL_EXEN];
               next_decrement_enable          = wr_data[AURT_CTRL_DECREMENT_ENABLE];
            end
            AURT_REG_COUNT_LOW: begin
               next_count[7:0] = wr_data;
            end
            AURT_REG_COUNT_HIGH: begin
               next_count[15:8] = wr_data;
            end
            AURT_REG_RELOAD_LOW: begin
               next_reload_value[7:0] = wr_data;
            end
            AURT_REG_RELOAD_HIGH: begin
               next_reload_value[15:8] = wr_data;
            end
            AURT_REG_IRQ_ENABLE: begin
               next_irq_enable = wr_data[AURT_STAT_W-1:0];
            end
            AURT_REG_EXT_FLAG: begin
               next_extension_toggle_flag = wr_data[0];
            end
            default: begin
            end
         endcase
      end

      // A new event in the clearing cycle keeps its bit set.
      next_status = (status & ~clear_mask) | events;
      next_irq    = |(next_status & next_irq_enable);

      if (rd_en) begin
         unique case (addr)
            AURT_REG_CTRL: begin
               next_rd_data = {4'h0, decrement_enable, ext_trigger_enable,
                               capture_not_reload_select, run_control};
            end
            AURT_REG_COUNT_LOW: begin
               next_rd_data = count[7:0];
            end
            AURT_REG_COUNT_HIGH: begin
               next_rd_data = count[15:8];
            end
            AURT_REG_RELOAD_LOW: begin
               next_rd_data = reload_value[7:0];
            end
            AURT_REG_RELOAD_HIGH: begin
               next_rd_data = reload_value[15:8];
            end
            AURT_REG_STATUS: begin
               next_rd_data = {{(AURT_DATA_W-AURT_STAT_W){1'b0}}, status};
            end
            AURT_REG_IRQ_ENABLE: begin
               next_rd_data = {{(AURT_DATA_W-AURT_STAT_W){1'b0}},
                               irq_enable};
            end
            AURT_REG_EXT_FLAG: begin
               next_rd_data = {7'h00, extension_toggle_flag};
            end
            default: begin
               next_rd_data = AURT_RDATA_RST;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_control               <= AURT_CTRL_RST[AURT_CTRL_RUN];
         capture_not_reload_select <= AURT_CTRL_RST[AURT_CTRL_CPRL];
         ext_trigger_enable        <= AURT_CTRL_RST[AURT_CTRL_EXEN];
         decrement_enable          <= AURT_CTRL_RST[AURT_CTRL_DECREMENT_ENABLE];
         count                     <= AURT_COUNT_RST;
         reload_value              <= AURT_RELOAD_RST;
         status                    <= AURT_STAT_RST;
         irq_enable                <= AURT_STAT_RST;
         extension_toggle_flag     <= 1'b0;
         overflow_flag             <= 1'b0;
         irq                       <= 1'b0;
         rd_data                   <= AURT_RDATA_RST;
      end else begin
         run_control               <= next_run_control;
         capture_not_reload_select <= next_capture_not_reload_select;
         ext_trigger_enable        <= next_ext_trigger_enable;
         decrement_enable          <= next_decrement_enable;
         count                     <= next_count;
         reload_value              <= next_reload_value;
         status                    <= next_status;
         irq_enable                <= next_irq_enable;
         extension_toggle_flag     <= next_extension_toggle_flag;
         overflow_flag             <= next_status[AURT_STAT_OVF];
         irq                       <= next_irq;
         rd_data                   <= next_rd_data;
      end
   end

endmodule : aurt_timer

// ### dv/aurt_timer_sva.sv
/*
 Port checker for the auto-reload timer, bound to its top module.
 Assumes one clock domain and a bus master that never overlaps strobes.
*/
`timescale 1ns/1ps
module aurt_timer_sva
   import aurt_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   sys_rst,
   input wire logic [AURT_ADDR_W-1:0] addr,
   input wire logic [AURT_DATA_W-1:0] wr_data,
   input wire logic                   wr_en,
   input wire logic                   rd_en,
   input wire logic [AURT_DATA_W-1:0] rd_data,
   input wire logic                   ext_timer_pin,
   input wire logic                   irq,
   input wire logic                   extension_toggle_flag,
   input wire logic                   overflow_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // -----------------------------------------------------------------
   // Sequences
   // -----------------------------------------------------------------
   sequence s_sel_write;
      wr_en && addr == AURT_REG_CTRL && wr_data[AURT_CTRL_CPRL];
   endsequence
   sequence s_quiet;
      !wr_en [*4];
   endsequence
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   AST_RDATA_IDLE: assert property (!rd_en |=> rd_data == 8'h00)
      else $error("read data not idle");
   AST_UNMAPPED: assert property (rd_en && addr > 4'h8 |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   AST_IRQ_MASK: assert property (
      wr_en && addr == AURT_REG_IRQ_ENABLE && wr_data == 8'h00 |=> !irq)
      else $error("irq stays with enable off");
   AST_EXT_TOGGLE: assert property (
      $rose(overflow_flag) |-> $changed(extension_toggle_flag))
      else $error("extension flag missed a wrap");
   AST_EXT_QUIET: assert property (
      $changed(extension_toggle_flag) |->
         overflow_flag || $past(wr_en && addr == AURT_REG_EXT_FLAG))
      else $error("extension flag moved without wrap");
   AST_OVF_READ: assert property (
      rd_en && addr == AURT_REG_STATUS |=> rd_data[0] == $past(overflow_flag))
      else $error("status read differs from flag");
   AST_OVF_STICKY: assert property (
      overflow_flag && !(wr_en && addr == AURT_REG_IRQ_CLEAR)
         |=> overflow_flag)
      else $error("overflow flag dropped alone");
   AST_CAPTURE_HALT: assert property (
      s_sel_write ##1 !overflow_flag ##0 s_quiet |-> !overflow_flag)
      else $error("counting in capture select");
endmodule : aurt_timer_sva

bind aurt_timer aurt_timer_sva i_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .ext_timer_pin(ext_timer_pin), .irq(irq),
   .extension_toggle_flag(extension_toggle_flag),
   .overflow_flag(overflow_flag));

// ### dv/tb.sv
/*
 Self-checking bench for the auto-reload timer over its register port.
 Assumes a step each clock while running, after the run write's edge.
*/
`timescale 1ns/1ps
module tb
   import aurt_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [3:0] addr    = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic       wr_en   = 1'b0;
   logic       rd_en   = 1'b0;
   logic       pin     = 1'b0;
   logic [7:0] rd_data;
   logic       irq;
   logic       ext_flag;
   logic       ovf;
   logic [7:0] rv;
   logic [7:0] rh;
   int         n_errors = 0;
   int         checked  = 0;
   int         cycles   = 0;

   aurt_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .ext_timer_pin(pin), .irq(irq), .extension_toggle_flag(ext_flag),
      .overflow_flag(ovf));

   initial begin
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge sys_clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      @(negedge sys_clk);
   endtask : wr

   task automatic rd(logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      @(negedge sys_clk);
      d = rd_data;
   endtask : rd

   task automatic chk_count(logic [15:0] e);
      rd(AURT_REG_COUNT_LOW, rv);
      rd(AURT_REG_COUNT_HIGH, rh);
      chk("count", e, {rh, rv});
   endtask : chk_count

   task automatic load(logic [15:0] rel, logic [15:0] cnt);
      wr(AURT_REG_RELOAD_LOW, rel[7:0]);
      wr(AURT_REG_RELOAD_HIGH, rel[15:8]);
      wr(AURT_REG_COUNT_LOW, cnt[7:0]);
      wr(AURT_REG_COUNT_HIGH, cnt[15:8]);
   endtask : load

   initial begin
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(AURT_REG_CTRL, rv);
      chk("ctrl", 16'h0000, {8'h00, rv});
      chk("flags", 16'h0000, {13'h0, irq, ext_flag, ovf});
      $display("reset test done");
      wr(AURT_REG_EXT_FLAG, 8'h01);
      rd(AURT_REG_EXT_FLAG, rv);
      chk("ext reg", 16'h0001, {8'h00, rv});
      wr(AURT_REG_EXT_FLAG, 8'h00);
      chk("ext", 16'h0000, {15'h0, ext_flag});
      load(16'hFFF0, 16'hFFFE);
      wr(AURT_REG_IRQ_ENABLE, 8'h01);
      wr(AURT_REG_CTRL, 8'h01);
      repeat (3) @(posedge sys_clk);
      wr(AURT_REG_CTRL, 8'h00);
      chk("flags", 16'h0007, {13'h0, irq, ext_flag, ovf});
      chk_count(16'hFFF3);
      wr(AURT_REG_IRQ_ENABLE, 8'h00);
      chk("irq", 16'h0000, {15'h0, irq});
      wr(AURT_REG_STATUS, 8'h00);
      rd(AURT_REG_STATUS, rv);
      chk("status", 16'h0001, {8'h00, rv});
      wr(AURT_REG_IRQ_CLEAR, 8'h01);
      chk("ovf", 16'h0000, {15'h0, ovf});
      rd(4'hF, rv);
      chk("unmapped", 16'h0000, {8'h00, rv});
      $display("up test done");
      wr(AURT_REG_CTRL, 8'h03);
      repeat (3) @(posedge sys_clk);
      wr(AURT_REG_CTRL, 8'h00);
      chk_count(16'hFFF3);
      $display("capture test done");
      wr(AURT_REG_IRQ_ENABLE, 8'h02);
      @(posedge sys_clk);
      pin <= 1'b1;
      load(16'h1234, 16'h0000);
      wr(AURT_REG_CTRL, 8'h05);
      @(posedge sys_clk);
      pin <= 1'b0;
      repeat (2) @(posedge sys_clk);
      wr(AURT_REG_CTRL, 8'h00);
      chk_count(16'h1237);
      rd(AURT_REG_STATUS, rv);
      chk("status", 16'h0002, {8'h00, rv});
      chk("irq", 16'h0001, {15'h0, irq});
      wr(AURT_REG_IRQ_CLEAR, 8'h03);
      chk("irq", 16'h0000, {15'h0, irq});
      $display("trigger test done");
      load(16'h0005, 16'h0007);
      wr(AURT_REG_CTRL, 8'h09);
      repeat (3) @(posedge sys_clk);
      wr(AURT_REG_CTRL, 8'h08);
      chk_count(16'hFFFD);
      rd(AURT_REG_STATUS, rv);
      chk("status", 16'h0001, {8'h00, rv});
      chk("ext", 16'h0000, {15'h0, ext_flag});
      @(posedge sys_clk);
      pin <= 1'b1;
      wr(AURT_REG_CTRL, 8'h09);
      wr(AURT_REG_CTRL, 8'h08);
      chk_count(16'hFFFF);
      wr(AURT_REG_IRQ_CLEAR, 8'h03);
      load(16'h0005, 16'h1000);
      wr(AURT_REG_CTRL, 8'h0D);
      @(posedge sys_clk);
      pin <= 1'b0;
      wr(AURT_REG_CTRL, 8'h0C);
      chk_count(16'h0FFF);
      rd(AURT_REG_STATUS, rv);
      chk("status", 16'h0000, {8'h00, rv});
      $display("down test done");
      close_out();
   end
endmodule : tb
